// file: hw/lvd_params.svh
// constants for the low-voltage detect control block
// assumes inclusion by bare name from files under hw/
`ifndef LVD_PARAMS_SVH
`define LVD_PARAMS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define PWR_CTL_ONE_OFF 8'h00
`define PWR_CTL_TWO_OFF 8'h04
`define RST_CAUSE_OFF 8'h08
`define IRQ_STATUS_OFF 8'h0c
`define IRQ_CLEAR_OFF 8'h10
`define IRQ_ENABLE_OFF 8'h14
`define STOP_REQ_OFF 8'h18
`define STATUS_OFF 8'h1c

// ----------------------------------------
// field positions
// ----------------------------------------
// power_control_one
`define P1_DETECT_FLAG 0
`define P1_DETECT_ACK 1
`define P1_DETECT_IE 2
`define P1_RESET_EN 3
`define P1_DETECTOR_EN 4
`define P1_STOP_EN 5
// power_control_two
`define P2_DETECT_VSEL 0
`define P2_WARN_VSEL 1
`define P2_WARN_FLAG 2
`define P2_WARN_ACK 3
// reset_cause_record
`define RC_LOW_VOLTAGE 0
`define RC_POWER_ON 1
// interrupt status bits
`define EV_DETECT 0
`define EV_WARN 1
`define EV_STOP_REFUSED 2
`define EV_WIDTH 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define P1_RESET_VAL 8'h1c
`define P2_RESET_VAL 8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 8
`define RELEASE_HOLD_NS 64
`define RELEASE_HOLD_CYC ((`RELEASE_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: hw/lvd_pkg.sv
// types for the low-voltage detect control block
// assumes no other package
`default_nettype none

package lvd_pkg;
    // requested stop depth
    typedef enum logic [1:0] {
        STOP_NONE,
        STOP_LIGHT,
        STOP_MID,
        STOP_DEEP
    } stop_mode_e;

    // reset sequencer states
    typedef enum logic [1:0] {
        SEQ_POWER_ON,
        SEQ_RUN,
        SEQ_LOW_HOLD,
        SEQ_RELEASE
    } seq_state_e;
endpackage

`default_nettype wire

// file: hw/pin_sync3.sv
// three-stage synchroniser with agreement filter for one comparator level
// assumes the input is asynchronous to clk_i
`default_nettype none

module pin_sync3 (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // asynchronous level, its reset value and its filtered copy
    input wire logic async_i,
    input wire logic rst_val_i,
    output logic level_o
);
    logic meta_r; // first stage, read only by stage two
    logic s2_r;
    logic s3_r;

    // shift chain
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            meta_r <= rst_val_i;
            s2_r <= rst_val_i;
            s3_r <= rst_val_i;
        end else begin
            meta_r <= async_i;
            s2_r <= meta_r;
            s3_r <= s2_r;
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            level_o <= rst_val_i;
        end else if (s2_r == s3_r) begin
            level_o <= s3_r;
        end
    end
endmodule

`default_nettype wire

// file: hw/low_voltage_detect_control.sv
// supply protection control: power-on and low-voltage reset, interrupt, warning
// assumes comparator outputs are asynchronous, high while supply is below level
//
// Local design decisions: strobed register access and the address map.
`default_nettype none
`include "lvd_params.svh"
//
// Summary of operation
// - detector active when enabled; select chooses trip level
// - stop switches detector off unless stop-enable
// - enable plus stop-enable refuses deep stops
// - power-on reset held until above low level
// - power-on sets both cause bits
// - reset-enable: low voltage resets until recovered
// - low-voltage reset sets low-voltage cause bit
// - interrupt mode sets flag, raises request
// - warning flag above detect level, no interrupt
// - warning select picks high or low level

module low_voltage_detect_control (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // analog comparators, high while supply below level
    input wire logic por_below_i,
    input wire logic below_high_trip_i,
    input wire logic below_low_trip_i,
    input wire logic below_high_warn_i,
    input wire logic below_low_warn_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // system outputs
    output logic sys_reset_o,
    output logic detect_irq_o,
    output logic irq_o,
    output logic [1:0] stop_mode_o,
    output logic analog_enable_o
);
    // ----------------------------------------
    // synchronised comparator levels
    // ----------------------------------------
    logic [4:0] raw_in;
    logic [4:0] cmp; // 0 por, 1 hi trip, 2 lo trip, 3 hi warn, 4 lo warn
    assign raw_in = {below_low_warn_i, below_high_warn_i, below_low_trip_i,
                     below_high_trip_i, por_below_i};

    // synchronisers reset to "below": after a reset nothing is trusted
    // until the filter has actually seen the rail above each level
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_sync
            pin_sync3 u_sync (
                .clk_i(clk_i),
                .rst_b_i(rst_b_i),
                .async_i(raw_in[gi]),
                .rst_val_i(1'b1),
                .level_o(cmp[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    logic detector_enable_r;
    logic detector_stop_enable_r;
    logic detect_reset_enable_r;
    logic detect_interrupt_enable_r;
    logic detect_flag_r;
    logic detect_voltage_select_r;
    logic warning_voltage_select_r;
    logic supply_warning_flag_r;
    logic [1:0] reset_cause_record_r;
    logic [`EV_WIDTH-1:0] irq_status_r;
    logic [`EV_WIDTH-1:0] irq_enable_r;
    lvd_pkg::stop_mode_e stop_mode_r;
    lvd_pkg::seq_state_e state_r;
    logic [7:0] hold_cnt_r;
    logic wr_p1, wr_p2, wr_clr, wr_en, wr_stop;
    logic ack_detect, ack_warn;
    logic below_trip, below_warn, detect_live, stopped;
    logic detect_evt, warn_evt, refuse_evt;
    logic [1:0] stop_req;

    assign wr_p1 = wr_i && (addr_i == `PWR_CTL_ONE_OFF);
    assign wr_p2 = wr_i && (addr_i == `PWR_CTL_TWO_OFF);
    assign wr_clr = wr_i && (addr_i == `IRQ_CLEAR_OFF);
    assign wr_en = wr_i && (addr_i == `IRQ_ENABLE_OFF);
    assign wr_stop = wr_i && (addr_i == `STOP_REQ_OFF);
    assign ack_detect = wr_p1 && wdata_i[`P1_DETECT_ACK];
    assign ack_warn = wr_p2 && wdata_i[`P2_WARN_ACK];
    assign stop_req = wdata_i[1:0];

    // ----------------------------------------
    // detector level selection
    // ----------------------------------------
    // stopped without stop-enable powers the detector down
    assign stopped = (stop_mode_r != lvd_pkg::STOP_NONE);
    assign detect_live = detector_enable_r && (!stopped || detector_stop_enable_r);
    assign analog_enable_o = detect_live;
    // select picks the high or the low trip comparator
    assign below_trip = detect_voltage_select_r ? cmp[1] : cmp[2];
    assign below_warn = warning_voltage_select_r ? cmp[3] : cmp[4];

    // events, one per cycle of condition
    // reset mode suppresses the flag; the sequencer acts instead
    assign detect_evt = detect_live && below_trip && !detect_reset_enable_r;
    assign warn_evt = detect_live && below_warn && !below_trip;
    assign refuse_evt = wr_stop && detector_enable_r && detector_stop_enable_r
                        && (stop_req > 2'd1);

    // ----------------------------------------
    // power_control_one: enables, detect flag
    // ----------------------------------------
    // settings survive a low-voltage reset but restore on power-on
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            detector_enable_r <= 1'b1;
            detector_stop_enable_r <= 1'b0;
            detect_reset_enable_r <= 1'b1;
            detect_interrupt_enable_r <= 1'b1;
        end else if (state_r == lvd_pkg::SEQ_POWER_ON) begin
            // power-on restores defaults; writes in this state are dropped
            detector_enable_r <= 1'(`P1_RESET_VAL >> `P1_DETECTOR_EN);
            detector_stop_enable_r <= 1'b0;
            detect_reset_enable_r <= 1'(`P1_RESET_VAL >> `P1_RESET_EN);
            detect_interrupt_enable_r <= 1'(`P1_RESET_VAL >> `P1_DETECT_IE);
        end else if (wr_p1) begin
            detector_enable_r <= wdata_i[`P1_DETECTOR_EN];
            detector_stop_enable_r <= wdata_i[`P1_STOP_EN];
            detect_reset_enable_r <= wdata_i[`P1_RESET_EN];
            detect_interrupt_enable_r <= wdata_i[`P1_DETECT_IE];
        end
    end

    // detect flag: set wins over acknowledge
    // any held system reset clears it as well
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || sys_reset_o) begin
            detect_flag_r <= 1'b0;
        end else if (detect_evt) begin
            detect_flag_r <= 1'b1;
        end else if (ack_detect) begin
            detect_flag_r <= 1'b0;
        end
    end
    assign detect_irq_o = detect_flag_r && detect_interrupt_enable_r;

    // ----------------------------------------
    // power_control_two: selects, warning flag
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || state_r == lvd_pkg::SEQ_POWER_ON) begin
            detect_voltage_select_r <= 1'b0;
            warning_voltage_select_r <= 1'b0;
        end else if (wr_p2) begin
            detect_voltage_select_r <= wdata_i[`P2_DETECT_VSEL];
            warning_voltage_select_r <= wdata_i[`P2_WARN_VSEL];
        end
    end

    // warning never drives detect_irq_o; it is polled
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || sys_reset_o) begin
            supply_warning_flag_r <= 1'b0;
        end else if (warn_evt) begin
            supply_warning_flag_r <= 1'b1;
        end else if (ack_warn) begin
            supply_warning_flag_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // stop mode request
    // ----------------------------------------
    // deep stops would cut detector power, so with enable and stop-enable set they are refused
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || sys_reset_o) begin
            stop_mode_r <= lvd_pkg::STOP_NONE;
        end else if (wr_stop) begin
            if (refuse_evt) begin
                // a refused deep request still lands as light stop
                stop_mode_r <= lvd_pkg::STOP_LIGHT;
            end else begin
                stop_mode_r <= lvd_pkg::stop_mode_e'(stop_req);
            end
        end
    end
    assign stop_mode_o = stop_mode_r;

    // ----------------------------------------
    // reset sequencer
    // ----------------------------------------
    // release waits a short settle time after the supply recovers
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_r <= lvd_pkg::SEQ_POWER_ON;
            hold_cnt_r <= 8'h00;
        end else if (cmp[0]) begin
            state_r <= lvd_pkg::SEQ_POWER_ON;
            hold_cnt_r <= 8'h00;
        end else begin
            case (state_r)
                lvd_pkg::SEQ_POWER_ON: begin
                    if (!cmp[2]) begin
                        state_r <= lvd_pkg::SEQ_RELEASE;
                        hold_cnt_r <= 8'h00;
                    end
                end
                lvd_pkg::SEQ_RUN: begin
                    if (detect_live && detect_reset_enable_r && below_trip) begin
                        state_r <= lvd_pkg::SEQ_LOW_HOLD;
                    end
                end
                lvd_pkg::SEQ_LOW_HOLD: begin
                    if (!below_trip) begin
                        state_r <= lvd_pkg::SEQ_RELEASE;
                        hold_cnt_r <= 8'h00;
                    end
                end
                lvd_pkg::SEQ_RELEASE: begin
                    if (below_trip && detect_reset_enable_r) begin
                        state_r <= lvd_pkg::SEQ_LOW_HOLD;
                    end else if (hold_cnt_r == 8'(`RELEASE_HOLD_CYC - 1)) begin
                        state_r <= lvd_pkg::SEQ_RUN;
                    end else begin
                        hold_cnt_r <= hold_cnt_r + 8'h01;
                    end
                end
                default: begin
                    state_r <= lvd_pkg::SEQ_POWER_ON;
                end
            endcase
        end
    end
    assign sys_reset_o = (state_r != lvd_pkg::SEQ_RUN);

    // ----------------------------------------
    // reset cause record
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || state_r == lvd_pkg::SEQ_POWER_ON) begin
            reset_cause_record_r <= 2'b11;
        end else if (state_r == lvd_pkg::SEQ_LOW_HOLD) begin
            // a low-voltage hold drops the power-on cause
            reset_cause_record_r <= 2'b01;
        end
    end

    // ----------------------------------------
    // interrupt status, enable, clear
    // ----------------------------------------
    // sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            irq_status_r <= '0;
        end else begin
            irq_status_r <= (irq_status_r & ~(wr_clr ? wdata_i[`EV_WIDTH-1:0] : 3'b000))
                            | {refuse_evt, warn_evt, detect_evt};
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            irq_enable_r <= '0;
        end else if (wr_en) begin
            irq_enable_r <= wdata_i[`EV_WIDTH-1:0];
        end
    end
    // warning status is readable but never raises the request line,
    // so its enable bit only keeps the register layout uniform
    logic [`EV_WIDTH-1:0] req_mask;
    assign req_mask = ~({{(`EV_WIDTH-1){1'b0}}, 1'b1} << `EV_WARN);
    assign irq_o = |(irq_status_r & irq_enable_r & req_mask);

    // ----------------------------------------
    // read port, data one cycle after strobe
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                `PWR_CTL_ONE_OFF: rdata_o <= {2'b00, detector_stop_enable_r, detector_enable_r,
                    detect_reset_enable_r, detect_interrupt_enable_r, 1'b0, detect_flag_r};
                `PWR_CTL_TWO_OFF: rdata_o <= {5'h00, supply_warning_flag_r,
                    warning_voltage_select_r, detect_voltage_select_r};
                `RST_CAUSE_OFF: rdata_o <= {6'h00, reset_cause_record_r};
                `IRQ_STATUS_OFF: rdata_o <= {5'h00, irq_status_r};
                `IRQ_ENABLE_OFF: rdata_o <= {5'h00, irq_enable_r};
                `STOP_REQ_OFF: rdata_o <= {6'h00, stop_mode_r};
                // live status: filtered levels, nothing sticky
                `STATUS_OFF: rdata_o <= {3'h0, sys_reset_o, detect_live, below_warn,
                    below_trip, cmp[0]};
                default: rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end
endmodule

`default_nettype wire

// file: sim/supply_model.sv
// comparator model of the supply rail feeding the detect control block
// assumes the bench sets the rail in millivolts; outputs high while below
`default_nettype none

module supply_model #(
    // trip points are plain defaults, not any part's levels
    parameter int POR_MV = 1800,
    parameter int LOW_TRIP_MV = 2000,
    parameter int HIGH_TRIP_MV = 2200,
    parameter int LOW_WARN_MV = 2400,
    parameter int HIGH_WARN_MV = 2600
) (
    // rail level and a forced dip of every comparator
    input wire logic [15:0] supply_mv_i,
    input wire logic glitch_i,
    // comparator levels
    output logic por_below_o,
    output logic low_trip_o,
    output logic high_trip_o,
    output logic low_warn_o,
    output logic high_warn_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // a dip drives all lines together, like a real rail sag
    assign por_below_o = glitch_i || int'(supply_mv_i) < POR_MV;
    assign low_trip_o = glitch_i || int'(supply_mv_i) < LOW_TRIP_MV;
    assign high_trip_o = glitch_i || int'(supply_mv_i) < HIGH_TRIP_MV;
    assign low_warn_o = glitch_i || int'(supply_mv_i) < LOW_WARN_MV;
    assign high_warn_o = glitch_i || int'(supply_mv_i) < HIGH_WARN_MV;
endmodule

`default_nettype wire

// file: sim/lvd_props.sv
// port checker for the low-voltage detect control block
// assumes a bind to the top module; control byte is shadowed from bus writes
`default_nettype none
`include "lvd_params.svh"

module lvd_props (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // comparators and register port
    input wire logic por_below_i,
    input wire logic below_high_trip_i,
    input wire logic below_low_trip_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    // observed outputs
    input wire logic [7:0] rdata_o,
    input wire logic sys_reset_o,
    input wire logic detect_irq_o,
    input wire logic [1:0] stop_mode_o,
    input wire logic analog_enable_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // shadow trusted only after a write outside any held reset
    logic [5:0] sh_r;
    logic sh_ok_r;
    logic en, ie, re, se;
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || sys_reset_o) begin
            sh_ok_r <= 1'b0;
            sh_r <= 6'h00;
        end else if (wr_i && addr_i == `PWR_CTL_ONE_OFF) begin
            sh_ok_r <= 1'b1;
            sh_r <= wdata_i[5:0];
        end
    end
    assign en = sh_ok_r && sh_r[`P1_DETECTOR_EN];
    assign ie = sh_r[`P1_DETECT_IE];
    assign re = sh_r[`P1_RESET_EN];
    assign se = sh_r[`P1_STOP_EN];
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside its slot");
    a_off_dark: assert property ((sh_ok_r && !en)[*2] |-> !analog_enable_o)
        else $error("detector powered while disabled");
    a_stop_dark: assert property ((sh_ok_r && stop_mode_o != 2'h0 && !se)[*2]
        |-> !analog_enable_o) else $error("detector powered in stop");
    a_deep_refused: assert property (en && se |-> stop_mode_o <= 2'h1)
        else $error("deep stop entered with detector kept");
    a_release_clean: assert property ($fell(sys_reset_o) |-> !por_below_i
        && !$past(below_low_trip_i, 8)) else $error("reset released while low");
    a_trip_reset: assert property ((en && re && stop_mode_o == 2'h0
        && below_low_trip_i)[*6] |-> ##[0:3] sys_reset_o) else $error("no trip reset");
    a_irq_mode: assert property ((en && ie && !re && stop_mode_o == 2'h0
        && below_low_trip_i)[*6] |-> ##[0:3] detect_irq_o) else $error("no detect request");
    a_glitch_wide: assert property ($rose(sys_reset_o) |-> $past(below_low_trip_i, 3)
        || $past(below_high_trip_i, 3) || $past(por_below_i, 3)) else $error("short dip reset");
    a_irq_cause: assert property ($rose(detect_irq_o) |-> $past(below_low_trip_i, 4)
        || $past(below_high_trip_i, 4)) else $error("request without trip");
    cover property ($rose(detect_irq_o));
    cover property ($rose(sys_reset_o));
    cover property (stop_mode_o == 2'h1);
endmodule

`default_nettype wire

// file: sim/low_voltage_detect_control_bench.sv
// self-checking bench for the low-voltage detect control block
// assumes the supply model and checker are compiled first
`default_nettype none
`include "lvd_params.svh"

module low_voltage_detect_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rst_b_i, wr_i, rd_i, glitch, sys_reset_o, detect_irq_o, irq_o;
    logic por_below_i, below_high_trip_i, below_low_trip_i, below_high_warn_i, below_low_warn_i;
    logic analog_enable_o;
    logic [7:0] addr_i, wdata_i, rdata_o;
    logic [1:0] stop_mode_o;
    logic [15:0] supply;
    int fail_count, num_checks, cyc;
    supply_model model (.supply_mv_i(supply), .glitch_i(glitch), .por_below_o(por_below_i),
        .low_trip_o(below_low_trip_i), .high_trip_o(below_high_trip_i),
        .low_warn_o(below_low_warn_i), .high_warn_o(below_high_warn_i));
    low_voltage_detect_control DUT (.clk_i, .rst_b_i, .por_below_i, .below_high_trip_i,
        .below_low_trip_i, .below_high_warn_i, .below_low_warn_i, .addr_i, .wdata_i, .wr_i,
        .rd_i, .rdata_o, .sys_reset_o, .detect_irq_o, .irq_o, .stop_mode_o, .analog_enable_o);
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, e);
    endtask
    // set the rail, then let n edges land
    task automatic sup(input logic [15:0] v, input int n);
        @(posedge clk_i);
        supply <= v;
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wait_rst(input logic v);
        for (int n = 0; n < 40 && sys_reset_o !== v; n++) begin
            @(posedge clk_i);
            #1;
        end
        chk({7'h0, sys_reset_o}, {7'h0, v});
    endtask
    task automatic t_irq();
        wr(`PWR_CTL_TWO_OFF, 8'h00);
        wr(`PWR_CTL_ONE_OFF, 8'h14);
        sup(16'd2100, 12);
        rd(`PWR_CTL_ONE_OFF, 8'h14);
        sup(16'd1900, 12);
        rd(`PWR_CTL_ONE_OFF, 8'h15);
        chk({6'h0, sys_reset_o, detect_irq_o}, 8'h01);
        sup(16'd3000, 12);
        wr(`PWR_CTL_ONE_OFF, 8'h16);
        rd(`PWR_CTL_ONE_OFF, 8'h14);
        $display("interrupt mode done");
    endtask
    task automatic t_warn();
        wr(`PWR_CTL_TWO_OFF, 8'h08);
        wr(`PWR_CTL_ONE_OFF, 8'h10);
        wr(`IRQ_CLEAR_OFF, 8'h07);
        wr(`IRQ_ENABLE_OFF, 8'h02);
        sup(16'd2500, 12);
        rd(`PWR_CTL_TWO_OFF, 8'h00);
        wr(`PWR_CTL_TWO_OFF, 8'h02);
        sup(16'd2500, 12);
        rd(`PWR_CTL_TWO_OFF, 8'h06);
        chk({6'h0, detect_irq_o, irq_o}, 8'h00);
        rd(`IRQ_STATUS_OFF, 8'h02);
        sup(16'd3000, 12);
        wr(`PWR_CTL_TWO_OFF, 8'h0a);
        wr(`IRQ_CLEAR_OFF, 8'h02);
        rd(`IRQ_STATUS_OFF, 8'h00);
        chk({7'h0, irq_o}, 8'h00);
        $display("warning done");
    endtask
    task automatic t_reset_mode();
        wr(`PWR_CTL_TWO_OFF, 8'h01);
        wr(`PWR_CTL_ONE_OFF, 8'h18);
        sup(16'd1900, 0);
        wait_rst(1'b1);
        sup(16'd2100, 30);
        chk({7'h0, sys_reset_o}, 8'h01);
        sup(16'd3000, 0);
        wait_rst(1'b0);
        rd(`RST_CAUSE_OFF, 8'h01);
        wr(`PWR_CTL_ONE_OFF, 8'h18);
        @(posedge clk_i);
        glitch <= 1'b1;
        @(posedge clk_i);
        glitch <= 1'b0;
        sup(16'd3000, 15);
        chk({7'h0, sys_reset_o}, 8'h00);
        $display("reset mode done");
    endtask
    task automatic t_stop();
        wr(`PWR_CTL_ONE_OFF, 8'h30);
        wr(`IRQ_ENABLE_OFF, 8'h04);
        wr(`IRQ_CLEAR_OFF, 8'h07);
        wr(`STOP_REQ_OFF, 8'h03);
        sup(16'd3000, 2);
        chk({5'h0, analog_enable_o, stop_mode_o}, 8'h05);
        chk({7'h0, irq_o}, 8'h01);
        rd(`IRQ_STATUS_OFF, 8'h04);
        wr(`STOP_REQ_OFF, 8'h00);
        wr(`PWR_CTL_ONE_OFF, 8'h10);
        wr(`STOP_REQ_OFF, 8'h03);
        sup(16'd3000, 2);
        chk({5'h0, analog_enable_o, stop_mode_o}, 8'h03);
        wr(`STOP_REQ_OFF, 8'h00);
        wr(`PWR_CTL_ONE_OFF, 8'h00);
        sup(16'd3000, 2);
        chk({7'h0, analog_enable_o}, 8'h00);
        rd(8'hfc, 8'h00);
        $display("stop done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // hang guard, well above the few hundred cycles the tests need
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            close_out();
        end
    end
    initial begin
        {rst_b_i, wr_i, rd_i, glitch, addr_i, wdata_i} = '0;
        supply = 16'd1900;
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'b1;
        sup(16'd1900, 30);
        chk({7'h0, sys_reset_o}, 8'h01);
        sup(16'd3000, 0);
        wait_rst(1'b0);
        rd(`RST_CAUSE_OFF, 8'h03);
        $display("power-up done");
        t_irq();
        t_warn();
        t_reset_mode();
        t_stop();
        close_out();
    end
endmodule

bind low_voltage_detect_control lvd_props u_props (.clk_i, .rst_b_i, .por_below_i,
    .below_high_trip_i, .below_low_trip_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .sys_reset_o, .detect_irq_o, .stop_mode_o, .analog_enable_o);

`default_nettype wire
